// >>> shared/decode_map.vh
`ifndef DECODE_MAP_VH
`define DECODE_MAP_VH

// Operand source selects
`define SRC_NONE 4'h0
`define SRC_REG 4'h1
`define SRC_DIRECT 4'h2
`define SRC_INDIRECT 4'h3
`define SRC_IMM 4'h4
`define SRC_ACC 4'h5
`define SRC_CODE_POINTER 4'h6
`define SRC_CODE_PC 4'h7
`define SRC_EXT_RI 4'h8
`define SRC_EXT_POINTER 4'h9
`define SRC_STACK 4'hA
`define SRC_BIT 4'hB
`define SRC_CARRY 4'hC
`define SRC_IMM16 4'hD

// Operation classes
`define OP_NONE 5'h00
`define OP_COPY 5'h01
`define OP_SWAP 5'h02
`define OP_SWAP_DIGIT 5'h03
`define OP_PUSH 5'h04
`define OP_POP 5'h05
`define OP_AND_BIT 5'h06
`define OP_AND_NBIT 5'h07
`define OP_OR_BIT 5'h08
`define OP_OR_NBIT 5'h09
`define OP_FAR_CALL 5'h0A
`define OP_FAR_JUMP 5'h0B
`define OP_PAGE_CALL 5'h0C
`define OP_PAGE_JUMP 5'h0D
`define OP_SHORT_JUMP 5'h0E
`define OP_IND_JUMP 5'h0F
`define OP_BR_ACC_ZERO 5'h10
`define OP_BR_ACC_NONZERO 5'h11
`define OP_BR_CARRY 5'h12
`define OP_BR_NO_CARRY 5'h13
`define OP_JBS 5'h14
`define OP_JBCLR 5'h15
`define OP_JBSCLR 5'h16
`define OP_CMP_BR 5'h17
`define OP_DEC_BR 5'h18

// Direct address split between low RAM and special registers
`define DIRECT_RAM_LIMIT 8'h80

`endif

// >>> verilog/move_bit_branch_decode.v
`include "decode_map.vh"

module move_bit_branch_decode (
    input wire clk,
    input wire resetn,
    input wire valid,
    input wire [7:0] opcode,
    input wire [7:0] byte2,
    input wire [7:0] byte3,
    input wire [15:0] pc,
    input wire [7:0] acc,
    input wire [15:0] sixteen_bit_pointer,
    input wire [1:0] bank,
    input wire [7:0] r0_value,
    input wire [7:0] r1_value,
    output reg known,
    output reg [1:0] length,
    output reg [1:0] cycles,
    output reg [4:0] op_class,
    output reg [3:0] src_sel,
    output reg [3:0] dst_sel,
    output reg [7:0] reg_addr,
    output reg [7:0] indirect_addr,
    output reg [7:0] direct_addr,
    output reg direct_is_special,
    output reg [7:0] imm_value,
    output reg [15:0] pointer_value,
    output reg [15:0] code_addr,
    output reg [15:0] ext_addr,
    output reg [15:0] branch_target,
    output reg [15:0] next_pc
);

    reg known_next;
    reg [1:0] length_next;
    reg [1:0] cycles_next;
    reg [4:0] op_next;
    reg [3:0] src_next;
    reg [3:0] dst_next;
    reg [7:0] dir_next;
    reg [7:0] imm_next;
    reg [15:0] target_next;
    wire [15:0] after_pc;
    wire [15:0] pc_plus2;
    wire [15:0] pc_plus3;
    wire [7:0] ri_value;
    wire [2:0] reg_sel;

    // Relative target from the first byte of the following instruction
    function [15:0] rel_target;
        input [15:0] base;
        input [7:0] offset;
        begin
            rel_target = base + {{8{offset[7]}}, offset};
        end
    endfunction

    function [7:0] bank_reg;
        input [1:0] bank_sel;
        input [2:0] index;
        begin
            bank_reg = {3'b000, bank_sel, index};
        end
    endfunction

    assign after_pc = pc + {14'h0000, length_next};
    // Fixed-length bases keep the decode free of a loop through length_next
    assign pc_plus2 = pc + 16'h0002;
    assign pc_plus3 = pc + 16'h0003;
    assign ri_value = opcode[0] ? r1_value : r0_value;
    assign reg_sel = opcode[2:0];

    always @* begin
        known_next = 1'b1;
        length_next = 2'd1;
        cycles_next = 2'd1;
        op_next = `OP_COPY;
        src_next = `SRC_NONE;
        dst_next = `SRC_NONE;
        dir_next = byte2;
        imm_next = byte2;
        target_next = 16'h0000;
        if (opcode[3:0] == 4'h1) begin
            length_next = 2'd2;
            cycles_next = 2'd2;
            op_next = opcode[4] ? `OP_PAGE_CALL : `OP_PAGE_JUMP;
            target_next = {pc_plus2[15:11], opcode[7:5], byte2};
        end else if (opcode[3]) begin
            // Register-coded groups
            case (opcode[7:4])
                4'hE: begin
                    src_next = `SRC_REG;
                    dst_next = `SRC_ACC;
                end
                4'hF: begin
                    src_next = `SRC_ACC;
                    dst_next = `SRC_REG;
                end
                4'hA: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    src_next = `SRC_DIRECT;
                    dst_next = `SRC_REG;
                end
                4'h8: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    src_next = `SRC_REG;
                    dst_next = `SRC_DIRECT;
                end
                4'hC: begin
                    op_next = `OP_SWAP;
                    src_next = `SRC_REG;
                    dst_next = `SRC_ACC;
                end
                4'hB: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    op_next = `OP_CMP_BR;
                    src_next = `SRC_IMM;
                    dst_next = `SRC_REG;
                    target_next = rel_target(pc_plus3, byte3);
                end
                4'hD: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    op_next = `OP_DEC_BR;
                    dst_next = `SRC_REG;
                    target_next = rel_target(pc_plus2, byte2);
                end
                default: begin
                    known_next = 1'b0;
                    op_next = `OP_NONE;
                end
            endcase
        end else begin
            case (opcode)
                8'hE5: begin
                    length_next = 2'd2;
                    src_next = `SRC_DIRECT;
                    dst_next = `SRC_ACC;
                end
                8'hE6, 8'hE7: begin
                    src_next = `SRC_INDIRECT;
                    dst_next = `SRC_ACC;
                end
                8'h74: begin
                    length_next = 2'd2;
                    src_next = `SRC_IMM;
                    dst_next = `SRC_ACC;
                end
                8'hF5: begin
                    length_next = 2'd2;
                    src_next = `SRC_ACC;
                    dst_next = `SRC_DIRECT;
                end
                8'hF6, 8'hF7: begin
                    src_next = `SRC_ACC;
                    dst_next = `SRC_INDIRECT;
                end
                8'h85: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    src_next = `SRC_DIRECT;
                    dst_next = `SRC_DIRECT;
                    dir_next = byte3;
                end
                8'h75: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    src_next = `SRC_IMM;
                    dst_next = `SRC_DIRECT;
                    imm_next = byte3;
                end
                8'h90: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    src_next = `SRC_IMM16;
                end
                8'h93, 8'h83: begin
                    cycles_next = 2'd2;
                    src_next = opcode[4] ? `SRC_CODE_POINTER : `SRC_CODE_PC;
                    dst_next = `SRC_ACC;
                end
                8'hE0, 8'hE2, 8'hE3: begin
                    cycles_next = 2'd2;
                    src_next = opcode[1] ? `SRC_EXT_RI : `SRC_EXT_POINTER;
                    dst_next = `SRC_ACC;
                end
                8'hF0, 8'hF2, 8'hF3: begin
                    cycles_next = 2'd2;
                    src_next = `SRC_ACC;
                    dst_next = opcode[1] ? `SRC_EXT_RI : `SRC_EXT_POINTER;
                end
                8'hC0, 8'hD0: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    op_next = opcode[4] ? `OP_POP : `OP_PUSH;
                    src_next = opcode[4] ? `SRC_STACK : `SRC_DIRECT;
                    dst_next = opcode[4] ? `SRC_DIRECT : `SRC_STACK;
                end
                8'hC5: begin
                    length_next = 2'd2;
                    op_next = `OP_SWAP;
                    src_next = `SRC_DIRECT;
                    dst_next = `SRC_ACC;
                end
                8'hC6, 8'hC7, 8'hD6, 8'hD7: begin
                    op_next = opcode[4] ? `OP_SWAP_DIGIT : `OP_SWAP;
                    src_next = `SRC_INDIRECT;
                    dst_next = `SRC_ACC;
                end
                8'h82, 8'hB0, 8'h72, 8'hA0: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    src_next = `SRC_BIT;
                    dst_next = `SRC_CARRY;
                    if (opcode == 8'h82)
                        op_next = `OP_AND_BIT;
                    else if (opcode == 8'hB0)
                        op_next = `OP_AND_NBIT;
                    else if (opcode == 8'h72)
                        op_next = `OP_OR_BIT;
                    else
                        op_next = `OP_OR_NBIT;
                end
                8'hA2: begin
                    length_next = 2'd2;
                    src_next = `SRC_BIT;
                    dst_next = `SRC_CARRY;
                end
                8'h92: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    src_next = `SRC_CARRY;
                    dst_next = `SRC_BIT;
                end
                8'h12, 8'h02: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    op_next = opcode[4] ? `OP_FAR_CALL : `OP_FAR_JUMP;
                    target_next = {byte2, byte3};
                end
                8'h80, 8'h60, 8'h70, 8'h40, 8'h50: begin
                    length_next = 2'd2;
                    cycles_next = 2'd2;
                    target_next = rel_target(pc_plus2, byte2);
                    if (opcode == 8'h80)
                        op_next = `OP_SHORT_JUMP;
                    else if (opcode == 8'h60)
                        op_next = `OP_BR_ACC_ZERO;
                    else if (opcode == 8'h70)
                        op_next = `OP_BR_ACC_NONZERO;
                    else if (opcode == 8'h40)
                        op_next = `OP_BR_CARRY;
                    else
                        op_next = `OP_BR_NO_CARRY;
                end
                8'h20, 8'h30, 8'h10: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    src_next = `SRC_BIT;
                    target_next = rel_target(pc_plus3, byte3);
                    if (opcode == 8'h20)
                        op_next = `OP_JBS;
                    else if (opcode == 8'h30)
                        op_next = `OP_JBCLR;
                    else
                        op_next = `OP_JBSCLR;
                end
                8'hB5, 8'hB4, 8'hB6, 8'hB7: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    op_next = `OP_CMP_BR;
                    src_next = (opcode == 8'hB5) ? `SRC_DIRECT : `SRC_IMM;
                    dst_next = opcode[1] ? `SRC_INDIRECT : `SRC_ACC;
                    target_next = rel_target(pc_plus3, byte3);
                end
                8'hD5: begin
                    length_next = 2'd3;
                    cycles_next = 2'd2;
                    op_next = `OP_DEC_BR;
                    dst_next = `SRC_DIRECT;
                    target_next = rel_target(pc_plus3, byte3);
                end
                8'h73: begin
                    cycles_next = 2'd2;
                    op_next = `OP_IND_JUMP;
                    target_next = {8'h00, acc} + sixteen_bit_pointer;
                end
                default: begin
                    known_next = 1'b0;
                    op_next = `OP_NONE;
                end
            endcase
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            known <= 1'b0;
            length <= 2'd0;
            cycles <= 2'd0;
            op_class <= `OP_NONE;
            src_sel <= `SRC_NONE;
            dst_sel <= `SRC_NONE;
            reg_addr <= 8'h00;
            indirect_addr <= 8'h00;
            direct_addr <= 8'h00;
            direct_is_special <= 1'b0;
            imm_value <= 8'h00;
            pointer_value <= 16'h0000;
            code_addr <= 16'h0000;
            ext_addr <= 16'h0000;
            branch_target <= 16'h0000;
            next_pc <= 16'h0000;
        end else if (valid) begin
            known <= known_next;
            length <= length_next;
            cycles <= cycles_next;
            op_class <= op_next;
            src_sel <= src_next;
            dst_sel <= dst_next;
            reg_addr <= bank_reg(bank, reg_sel);
            indirect_addr <= ri_value;
            direct_addr <= dir_next;
            direct_is_special <= (dir_next >= `DIRECT_RAM_LIMIT);
            imm_value <= imm_next;
            pointer_value <= {byte2, byte3};
            // PC-relative base is the following instruction
            code_addr <= {8'h00, acc} + (opcode[4] ? sixteen_bit_pointer : after_pc);
            ext_addr <= opcode[1] ? {8'h00, ri_value} : sixteen_bit_pointer;
            branch_target <= target_next;
            next_pc <= after_pc;
        end
    end

endmodule // move_bit_branch_decode

// >>> verif/decode_checker_sva.sv
module decode_checker (
    input wire clk,
    input wire resetn,
    input wire valid,
    input wire [7:0] opcode,
    input wire [7:0] byte2,
    input wire [7:0] byte3,
    input wire [15:0] pc,
    input wire [7:0] acc,
    input wire [15:0] sixteen_bit_pointer,
    input wire [1:0] bank,
    input wire [7:0] r0_value,
    input wire [7:0] r1_value,
    input wire [1:0] length,
    input wire [1:0] cycles,
    input wire [4:0] op_class,
    input wire [7:0] reg_addr,
    input wire [7:0] indirect_addr,
    input wire [15:0] code_addr,
    input wire [15:0] ext_addr,
    input wire [15:0] branch_target,
    input wire [15:0] next_pc
);
    timeunit 1ns;
    timeprecision 1ns;
    wire [15:0] pc2 = pc + 16'h0002;
    wire [15:0] short_tgt = pc2 + {{8{byte2[7]}}, byte2};
    wire [15:0] page_tgt = {pc2[15:11], opcode[7:5], byte2};
    wire [7:0] reg_loc = {3'h0, bank, opcode[2:0]};
    wire [7:0] ri = opcode[0] ? r1_value : r0_value;
    wire [15:0] sum_ptr = {8'h00, acc} + sixteen_bit_pointer;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    far_jump_a: assert property (valid && opcode == 8'h02 |=> length == 2'h3
        && cycles == 2'h2 && branch_target == {$past(byte2), $past(byte3)})
        else $error("far jump bad");
    short_jump_a: assert property (valid && opcode == 8'h80 |=> op_class == 5'h0E
        && branch_target == $past(short_tgt)) else $error("short jump target bad");
    page_target_a: assert property (valid && opcode[4:0] == 5'h01 |=> length == 2'h2
        && branch_target == $past(page_tgt)) else $error("page target bad");
    next_pc_a: assert property (valid |=> next_pc == $past(pc) + {14'h0000, length})
        else $error("next address bad");
    reg_select_a: assert property (valid && opcode[7:3] == 5'h1D
        |=> reg_addr == $past(reg_loc)) else $error("register address bad");
    indirect_reg_a: assert property (valid && opcode[7:1] == 7'h73
        |=> indirect_addr == $past(ri)) else $error("indirect address bad");
    ext_pointer_a: assert property (valid && opcode[4:0] == 5'h00
        && opcode[7:5] == 3'h7 |=> ext_addr == $past(sixteen_bit_pointer)
        && cycles == 2'h2) else $error("external address bad");
    code_read_a: assert property (valid && opcode == 8'h93 |=> cycles == 2'h2
        && code_addr == $past(sum_ptr)) else $error("code read address bad");
    index_jump_a: assert property (valid && opcode == 8'h73 |=> length == 2'h1
        && branch_target == $past(sum_ptr)) else $error("indexed jump bad");
    cover property (valid && opcode == 8'h02);
    cover property (valid && opcode[4:0] == 5'h01);
    cover property (valid && opcode == 8'h80 && byte2[7]);
endmodule // decode_checker

// >>> verif/code_memory.sv
module code_memory (
    input wire [15:0] addr,
    output wire [7:0] first_byte,
    output wire [7:0] second_byte,
    output wire [7:0] third_byte
);
    timeunit 1ns;
    timeprecision 1ns;
    // Low address byte only; bench loads each instruction before use
    logic [7:0] mem [0:255];
    assign first_byte = mem[addr[7:0]];
    assign second_byte = mem[addr[7:0] + 8'h01];
    assign third_byte = mem[addr[7:0] + 8'h02];
endmodule // code_memory

// >>> verif/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic valid = 1'b0;
    logic [15:0] pc = 16'h0000;
    logic [41:0] core_state = 42'h0;
    wire [7:0] acc, r0_value, r1_value, opcode, byte2, byte3;
    wire [7:0] reg_addr, indirect_addr, direct_addr, imm_value;
    wire [15:0] sixteen_bit_pointer, pointer_value, code_addr, ext_addr, branch_target, next_pc;
    wire [1:0] bank, length, cycles;
    wire [4:0] op_class;
    wire [3:0] src_sel, dst_sel;
    wire known, direct_is_special;
    int failures = 0;
    int checks = 0;
    int ticks = 0;
    assign {acc, sixteen_bit_pointer, bank, r0_value, r1_value} = core_state;
    initial begin
        forever #25 clk = ~clk;
    end
    code_memory u_code (.addr(pc), .first_byte(opcode), .second_byte(byte2), .third_byte(byte3));
    move_bit_branch_decode DUT (.clk, .resetn, .valid, .opcode, .byte2, .byte3, .pc, .acc,
        .sixteen_bit_pointer, .bank, .r0_value, .r1_value, .known, .length, .cycles, .op_class,
        .src_sel, .dst_sel, .reg_addr, .indirect_addr, .direct_addr, .direct_is_special,
        .imm_value, .pointer_value, .code_addr, .ext_addr, .branch_target, .next_pc);
    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        ticks <= ticks + 1;
        if (ticks == 3000) begin
            failures = failures + 1;
            finish_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic set_core(input logic [41:0] s);
        @(posedge clk);
        core_state <= s;
    endtask
    task automatic issue(input logic [15:0] at, input logic [7:0] b0, input logic [7:0] b1,
            input logic [7:0] b2);
        @(posedge clk);
        u_code.mem[at[7:0]] <= b0;
        u_code.mem[at[7:0] + 8'h01] <= b1;
        u_code.mem[at[7:0] + 8'h02] <= b2;
        pc <= at;
        valid <= 1'b1;
        @(posedge clk);
        valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic branch_case(input logic [15:0] at, input logic [7:0] b0,
            input logic [7:0] b1, input logic [7:0] b2, input logic [15:0] exp);
        issue(at, b0, b1, b2);
        check(branch_target, exp);
    endtask
    // Entry: opcode, operation class, length, cycles
    task automatic t_table;
        logic [23:0] tbl [$] = '{24'hE801_11, 24'hEF01_11, 24'hE501_21, 24'hE601_11,
            24'hE701_11, 24'h7401_21, 24'hFF01_11, 24'hF501_21, 24'hF601_11, 24'hF701_11,
            24'hA801_22, 24'h8F01_22, 24'h8501_32, 24'h7501_32, 24'h9001_32, 24'h9301_12,
            24'h8301_12, 24'hE001_12, 24'hE201_12, 24'hE301_12, 24'hF001_12, 24'hF201_12,
            24'hF301_12, 24'hC004_22, 24'hD005_22, 24'hCC02_11, 24'hC502_21, 24'hC602_11,
            24'hC702_11, 24'hD603_11, 24'hD703_11, 24'h8206_22, 24'hB007_22, 24'h7208_22,
            24'hA009_22, 24'hA201_21, 24'h9201_22, 24'h120A_32, 24'h020B_32, 24'h110C_22,
            24'h210D_22, 24'h800E_22, 24'h730F_12, 24'h6010_22, 24'h7011_22, 24'h4012_22,
            24'h5013_22, 24'h2014_32, 24'h3015_32, 24'h1016_32, 24'hB517_32, 24'hB417_32,
            24'hB817_32, 24'hB617_32, 24'hB717_32, 24'hDF18_22, 24'hD518_32, 24'h0000_11,
            24'h2200_11, 24'h7800_11};
        foreach (tbl[i]) begin
            issue(16'h0020, tbl[i][23:16], 8'h00, 8'h00);
            check({2'h0, known, op_class, 2'h0, length, 2'h0, cycles}, // to
                {2'h0, |tbl[i][15:8], tbl[i][12:0]});
        end
    endtask
    // Entry: opcode, source select, destination select
    task automatic t_operands;
        logic [15:0] ops [0:19] = '{16'hE815, 16'hF552, 16'hE635, 16'h7445, 16'h9365,
            16'h8375, 16'hE095, 16'hF258, 16'hC02A, 16'hD0A2, 16'h92CB, 16'hA2BC,
            16'h90D0, 16'hB643, 16'hB525, 16'hA821, 16'h8812, 16'h8522, 16'hD502,
            16'hD735};
        foreach (ops[i]) begin
            issue(16'h0030, ops[i][15:8], 8'h00, 8'h00);
            check({8'h00, src_sel, dst_sel}, {8'h00, ops[i][7:0]}); // to
        end
    endtask
    task automatic t_branch;
        branch_case(16'h0040, 8'h02, 8'h12, 8'h34, 16'h1234);
        check(next_pc, 16'h0043);
        branch_case(16'h0100, 8'h80, 8'h80, 8'h00, 16'h0082);
        branch_case(16'h0100, 8'h80, 8'h7F, 8'h00, 16'h0181);
        branch_case(16'h0400, 8'h60, 8'hF0, 8'h00, 16'h03F2);
        branch_case(16'h0200, 8'h10, 8'h33, 8'hFE, 16'h0201);
        branch_case(16'h0500, 8'hB4, 8'h01, 8'h80, 16'h0483);
        branch_case(16'h0300, 8'hDA, 8'h05, 8'h00, 16'h0307);
        branch_case(16'h07FE, 8'h11, 8'h9C, 8'h00, 16'h089C);
        branch_case(16'h1000, 8'hE1, 8'h55, 8'h00, 16'h1755);
    endtask
    task automatic t_data;
        set_core({8'h10, 16'h1FF8, 2'h0, 8'h5A, 8'hA5});
        branch_case(16'h0010, 8'h73, 8'h00, 8'h00, 16'h2008);
        issue(16'h0010, 8'h93, 8'h00, 8'h00);
        check(code_addr, 16'h2008);
        issue(16'h0300, 8'h83, 8'h00, 8'h00);
        check(code_addr, 16'h0311);
        issue(16'h0010, 8'h90, 8'hAB, 8'hCD);
        check(pointer_value, 16'hABCD);
        issue(16'h0010, 8'h85, 8'h11, 8'h22);
        check({8'h00, direct_addr}, 16'h0022);
        issue(16'h0010, 8'h75, 8'h33, 8'h44);
        check({8'h00, imm_value}, 16'h0044);
        issue(16'h0010, 8'hE2, 8'h00, 8'h00);
        check(ext_addr, 16'h005A);
        issue(16'h0010, 8'hF3, 8'h00, 8'h00);
        check(ext_addr, 16'h00A5);
        issue(16'h0010, 8'hE7, 8'h00, 8'h00);
        check({8'h00, indirect_addr}, 16'h00A5);
        issue(16'h0010, 8'hE5, 8'h80, 8'h00);
        check({15'h0000, direct_is_special}, 16'h0001);
        issue(16'h0010, 8'hE5, 8'h7F, 8'h00);
        check({15'h0000, direct_is_special}, 16'h0000);
        for (int b = 0; b < 4; b++) begin
            set_core({8'h10, 16'h1FF8, b[1:0], 8'h5A, 8'hA5});
            issue(16'h0010, 8'hEB, 8'h00, 8'h00);
            check({8'h00, reg_addr}, {11'h000, b[1:0], 3'h3});
        end
    endtask
    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        check({10'h000, known, op_class}, 16'h0000);
        t_table();
        t_operands();
        t_branch();
        t_data();
        finish_test();
    end
endmodule // tb
bind move_bit_branch_decode decode_checker u_check (.clk, .resetn, .valid, .opcode, .byte2,
    .byte3, .pc, .acc, .sixteen_bit_pointer, .bank, .r0_value, .r1_value, .length, .cycles,
    .op_class, .reg_addr, .indirect_addr, .code_addr, .ext_addr, .branch_target, .next_pc);
